/* core/bbr_pkg.sv */
// constants and carrier types of the backlight/bias serial register port
// assumes a two-wire serial master and a separate analog/sequencing core
package bbr_pkg;

  // ****************************************
  // bus addressing and byte framing
  // ****************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h29;
  localparam logic [3:0] LAST_BIT   = 4'h7;  // eighth bit of a byte
  localparam logic [3:0] ACK_SLOT   = 4'h8;  // ninth clock of a byte
  localparam int         REG_COUNT  = 13;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFF_DEVICE_CONTROL        = 8'h00;
  localparam logic [7:0] OFF_BRIGHTNESS_LOW_BITS   = 8'h01;
  localparam logic [7:0] OFF_BRIGHTNESS_HIGH_BITS  = 8'h02;
  localparam logic [7:0] OFF_FAULT_FLAGS           = 8'h03;
  localparam logic [7:0] OFF_FAULT_AND_POWER_GOOD  = 8'h04;
  localparam logic [7:0] OFF_AUTO_FREQ_THRESHOLD   = 8'h05;
  localparam logic [7:0] OFF_BACKLIGHT_STRING_CFG  = 8'h06;
  localparam logic [7:0] OFF_BACKLIGHT_BOOST_CFG   = 8'h07;
  localparam logic [7:0] OFF_PWM_INPUT_CFG         = 8'h08;
  localparam logic [7:0] OFF_SLOPE_DITHER_CFG      = 8'h09;
  localparam logic [7:0] OFF_BIAS_ENABLE_DISCHARGE = 8'h0a;
  localparam logic [7:0] OFF_CONTROLLER_REG_SEQ    = 8'h0b;
  localparam logic [7:0] OFF_OUTPUT_LEVEL_SELECT   = 8'h0c;

  // ****************************************
  // reset values and writable bits, index 12 first
  // ****************************************
  localparam logic [REG_COUNT-1:0][7:0] RESET_BANK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hcf, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  localparam logic [REG_COUNT-1:0][7:0] WRITE_MASK = {
    8'hff, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h2f,
    8'hff, 8'h00, 8'h00, 8'hff, 8'h07, 8'h03};

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    BBR_IDLE = 3'b000,
    BBR_ADDR = 3'b001,
    BBR_REGA = 3'b011,
    BBR_WR   = 3'b010,
    BBR_RD   = 3'b110
  } bbr_phase_type;

  // fault events, ordered as the two flag registers read
  typedef struct packed {
    logic backlight_short_flag;
    logic thermal_shutdown_flag;
    logic backlight_current_limit_flag;
    logic backlight_overvoltage_flag;
    logic bias_boost_overvoltage_flag;
    logic reference_regulator_short_flag;
    logic positive_regulator_short_flag;
    logic undervoltage_flag;
    logic negative_pump_short_flag;
    logic negative_pump_overvoltage_flag;
    logic controller_regulator_limit_flag;
  } bbr_fault_type;

  typedef struct packed {
    logic        backlight_on;
    logic        bias_supplies_on;
    logic [10:0] brightness_code;
    logic [7:0]  frequency_switch_threshold;
    logic        linear_curve_select;
    logic        single_string_mode;
    logic        small_inductor_select;
    logic [1:0]  switch_current_limit;
    logic [1:0]  comp_integral_select;
    logic [1:0]  comp_proportional_select;
    logic        automatic_frequency_mode;
    logic [1:0]  boost_overvoltage_target;
    logic        boost_frequency_select;
    logic        pwm_measure_edge_select;
    logic        pwm_active_high;
    logic [1:0]  pwm_hysteresis_select;
    logic [1:0]  brightness_source_select;
    logic        advanced_ramp_enable;
    logic        dither_disable;
    logic [3:0]  ramp_time_select;
    logic [3:0]  dither_rate_select;
    logic [3:0]  discharge_enable;
    logic        positive_bias_regulator;
    logic        negative_bias_pump;
    logic        reference_regulator;
    logic [2:0]  controller_supply_startup_wait;
    logic [2:0]  controller_supply_shutdown_wait;
    logic        controller_supply_regulator;
    logic [1:0]  controller_supply_level;
    logic [5:0]  bias_boost_level;
  } bbr_settings_type;

  typedef struct packed {
    bbr_phase_type              phase;
    logic [3:0]                 cnt;
    logic [7:0]                 shift;
    logic                       rw;
    logic                       ack_ok;
    logic [7:0]                 ptr;
    logic [REG_COUNT-1:0][7:0]  bank;
    logic                       wr_tgl;
    logic                       clr_tgl;
    logic [10:0]                clr_mask;
    logic                       start_ack;
    logic                       stop_ack;
    logic [11:0]                flag_meta;
    logic [11:0]                flag_sync;
  } bbr_link_type;

  typedef struct packed {
    logic [2:0]                 wr_sync;
    logic [2:0]                 clr_sync;
    logic [10:0]                fault_meta;
    logic [10:0]                fault_sync;
    logic                       pg_meta;
    logic                       pg_sync;
    logic [10:0]                flags;
    logic [REG_COUNT-1:0][7:0]  bank;
    logic                       boost_hi;
  } bbr_sys_type;

endpackage

/* core/bbr_register_port.sv */
// serial slave port and control/status register bank of the backlight/bias core
// assumes SCL_CLK is the bus clock pin, SDA is resolved outside from SDA_OE
// Function
// [RULE_01] write: start, address with write bit, register address, data; each acked
// [RULE_02] each further written byte advances the register pointer after its ack
// [RULE_03] master closes a write with a stop after the last data ack
// [RULE_04] read: address write first, repeated start, address with read bit
// [RULE_05] master ack on a read byte advances pointer and sends next register
// [RULE_06] master ends a read by not acking, then a stop
// [RULE_07] register 0 bit 1 turns bias supplies on, bit 0 the backlight
// [RULE_08] brightness code is register 2 above the low three bits of register 1
// [RULE_09] register 3 holds eight latched fault flags, backlight short down to undervoltage
// [RULE_10] register 4 holds pump short, pump overvoltage, regulator limit, power good
// [RULE_11] auto mode sets boost frequency high when brightness top exceeds threshold
// [RULE_12] register 6 holds curve, string mode, inductor and switch current limit
// [RULE_13] register 7 holds compensation, auto mode, overvoltage target, frequency
// [RULE_14] register 8 bits 7 and 6 pick pwm measure edge and active level
// [RULE_15] register 8 bits 5:4 pick pwm hysteresis
// [RULE_16] register 8 bits 3:2 pick the brightness source
// [RULE_17] register 8 bit 1 enables advanced ramp, bit 0 disables dither
// [RULE_18] register 9 bits 7:4 pick brightness transition time
// [RULE_19] register 9 bits 3:0 pick dither rate
// [RULE_20] register 0x0a holds regulator enables and discharge resistor enables
// [RULE_21] register 0x0b holds controller regulator enable and its start and stop waits
// [RULE_22] register 0x0c holds controller regulator level and bias boost level
// [RULE_23] only slave address 0x29 is acked; following bit is the direction
// [RULE_24] writing one to the undervoltage bit clears its latched flag
// [RULE_25] unused bits read zero and ignore writes; writes land at the data ack
module bbr_register_port (
  input  wire logic                      SYS_CLK,
  input  wire logic                      RST,
  input  wire logic                      SCL_CLK,
  input  wire logic                      SDA_IN,
  output logic                           SDA_OUT,
  output logic                           SDA_OE,
  input  wire bbr_pkg::bbr_fault_type    FAULT_EVENTS,
  input  wire logic                      POWER_GOOD,
  output bbr_pkg::bbr_settings_type      SETTINGS
);

  // ****************************************
  // shared decode
  // ****************************************

  // effective boost frequency select, forced in auto mode
  function automatic logic boost_sel(input logic [7:0] brt_hi,
                                     input logic [7:0] thres,
                                     input logic [7:0] cfg);
    boost_sel = cfg[3] ? (brt_hi > thres) : cfg[0];
  endfunction

  // read value of one offset
  function automatic logic [7:0] read_reg(
      input logic [7:0]                          p,
      input logic [bbr_pkg::REG_COUNT-1:0][7:0]  b,
      input logic [11:0]                         fl);
    if (p == bbr_pkg::OFF_FAULT_FLAGS)
      read_reg = fl[11:4];
    else if (p == bbr_pkg::OFF_FAULT_AND_POWER_GOOD)
      read_reg = {4'h0, fl[3:0]};
    else if (p == bbr_pkg::OFF_BACKLIGHT_BOOST_CFG)
      read_reg = {b[7][7:1], boost_sel(b[2], b[5], b[7])};
    else if (p > bbr_pkg::OFF_OUTPUT_LEVEL_SELECT)
      read_reg = 8'h00;
    else
      read_reg = b[p[3:0]];
  endfunction

  // ****************************************
  // start and stop detection on data edges
  // ****************************************
  logic start_tgl;
  logic stop_tgl;
  logic start_pend;
  logic stop_pend;
  logic sda_oe;

  // falling data while clock high marks a start
  always_ff @(negedge SDA_IN or posedge RST) begin
    if (RST) begin
      start_tgl <= 1'b0;
    end else if (SCL_CLK) begin
      start_tgl <= ~start_tgl;
    end
  end

  // rising data while clock high marks a stop
  always_ff @(posedge SDA_IN or posedge RST) begin
    if (RST) begin
      stop_tgl <= 1'b0;
    end else if (SCL_CLK) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // ****************************************
  // link domain, clocked by the bus clock
  // ****************************************
  bbr_pkg::bbr_link_type lk;
  bbr_pkg::bbr_link_type next_lk;
  bbr_pkg::bbr_sys_type  sy;
  bbr_pkg::bbr_sys_type  next_sy;

  assign start_pend = start_tgl != lk.start_ack;
  assign stop_pend  = stop_tgl != lk.stop_ack;

  // byte framing, addressing and register writes
  always_comb begin
    next_lk = lk;
    next_lk.flag_meta = {sy.flags, sy.pg_sync};
    next_lk.flag_sync = lk.flag_meta;
    if (start_pend) begin
      // a start or repeated start opens an address byte
      next_lk.start_ack = start_tgl;
      next_lk.stop_ack  = stop_tgl;
      next_lk.phase     = bbr_pkg::BBR_ADDR;
      next_lk.cnt       = 4'h1;
      next_lk.shift     = {7'h00, SDA_IN};
      next_lk.ack_ok    = 1'b0;
    end else if (stop_pend) begin
      next_lk.stop_ack = stop_tgl;                        // [RULE_03]
      next_lk.phase    = bbr_pkg::BBR_IDLE;
      next_lk.cnt      = 4'h0;
    end else if (lk.phase != bbr_pkg::BBR_IDLE) begin
      if (lk.cnt != bbr_pkg::ACK_SLOT) begin
        next_lk.cnt = lk.cnt + 4'h1;
        if (lk.phase == bbr_pkg::BBR_RD) begin
          next_lk.shift = {lk.shift[6:0], 1'b0};
        end else begin
          next_lk.shift = {lk.shift[6:0], SDA_IN};
        end
        if (lk.cnt == bbr_pkg::LAST_BIT) begin
          // decide the ack of a complete byte
          next_lk.ack_ok = (lk.phase != bbr_pkg::BBR_ADDR) ||
                           (lk.shift[6:0] == bbr_pkg::SLAVE_ADDR); // [RULE_23]
          if (lk.phase == bbr_pkg::BBR_ADDR) begin
            next_lk.rw = SDA_IN;                          // [RULE_23]
          end
        end
      end else begin
        next_lk.cnt = 4'h0;
        unique case (lk.phase)
          bbr_pkg::BBR_ADDR: begin
            if (!lk.ack_ok) begin
              next_lk.phase = bbr_pkg::BBR_IDLE;
            end else if (lk.rw) begin
              next_lk.phase = bbr_pkg::BBR_RD;            // [RULE_04]
              next_lk.shift = read_reg(lk.ptr, lk.bank, lk.flag_sync);
            end else begin
              next_lk.phase = bbr_pkg::BBR_REGA;          // [RULE_01]
            end
          end
          bbr_pkg::BBR_REGA: begin
            next_lk.ptr   = lk.shift;                     // [RULE_01]
            next_lk.phase = bbr_pkg::BBR_WR;
          end
          bbr_pkg::BBR_WR: begin
            if (lk.ptr <= bbr_pkg::OFF_OUTPUT_LEVEL_SELECT) begin
              next_lk.bank[lk.ptr[3:0]] =
                lk.shift & bbr_pkg::WRITE_MASK[lk.ptr[3:0]]; // [RULE_25]
            end
            if (lk.ptr == bbr_pkg::OFF_FAULT_FLAGS) begin
              next_lk.clr_mask = {lk.shift, 3'b000};      // [RULE_24]
              next_lk.clr_tgl  = ~lk.clr_tgl;
            end else if (lk.ptr == bbr_pkg::OFF_FAULT_AND_POWER_GOOD) begin
              next_lk.clr_mask = {8'h00, lk.shift[3:1]};
              next_lk.clr_tgl  = ~lk.clr_tgl;
            end
            next_lk.wr_tgl = ~lk.wr_tgl;
            next_lk.ptr    = lk.ptr + 8'h01;              // [RULE_02]
          end
          bbr_pkg::BBR_RD: begin
            if (!SDA_IN) begin
              next_lk.ptr   = lk.ptr + 8'h01;             // [RULE_05]
              next_lk.shift = read_reg(lk.ptr + 8'h01, lk.bank, lk.flag_sync);
            end else begin
              next_lk.phase = bbr_pkg::BBR_IDLE;          // [RULE_06]
            end
          end
          default: begin
            next_lk.phase = bbr_pkg::BBR_IDLE;
          end
        endcase
      end
    end
  end

  // link state register
  always_ff @(posedge SCL_CLK or posedge RST) begin
    if (RST) begin
      lk      <= '0;
      lk.bank <= bbr_pkg::RESET_BANK;
    end else begin
      lk <= next_lk;
    end
  end

  // data line driven while clock is low: ack slots and read bits
  always_ff @(negedge SCL_CLK or posedge RST) begin
    if (RST) begin
      sda_oe <= 1'b0;
    end else if (lk.phase == bbr_pkg::BBR_RD) begin
      sda_oe <= (lk.cnt != bbr_pkg::ACK_SLOT) && !lk.shift[7];  // [RULE_05]
    end else begin
      sda_oe <= (lk.phase != bbr_pkg::BBR_IDLE) &&
                (lk.cnt == bbr_pkg::ACK_SLOT) && lk.ack_ok;     // [RULE_01]
    end
  end

  assign SDA_OE  = sda_oe;
  assign SDA_OUT = 1'b0;  // open drain, only ever pulls low

  // ****************************************
  // system domain: settings copy and fault flags
  // ****************************************
  logic wr_evt;
  logic clr_evt;

  assign wr_evt  = sy.wr_sync[2] ^ sy.wr_sync[1];
  assign clr_evt = sy.clr_sync[2] ^ sy.clr_sync[1];

  // synchronisers, sticky flags, bank copy on each write
  always_comb begin
    next_sy = sy;
    next_sy.wr_sync    = {sy.wr_sync[1:0], lk.wr_tgl};
    next_sy.clr_sync   = {sy.clr_sync[1:0], lk.clr_tgl};
    next_sy.fault_meta = FAULT_EVENTS;
    next_sy.fault_sync = sy.fault_meta;
    next_sy.pg_meta    = POWER_GOOD;
    next_sy.pg_sync    = sy.pg_meta;
    // a new event wins over a clear in the same cycle
    next_sy.flags = (sy.flags & ~(clr_evt ? lk.clr_mask : 11'h000)) |
                    sy.fault_sync;                        // [RULE_09] [RULE_10] [RULE_24]
    if (wr_evt) begin
      next_sy.bank = lk.bank;                             // [RULE_25]
    end
    next_sy.boost_hi = boost_sel(sy.bank[2], sy.bank[5], sy.bank[7]); // [RULE_11]
  end

  // system state register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sy      <= '0;
      sy.bank <= bbr_pkg::RESET_BANK;
    end else begin
      sy <= next_sy;
    end
  end

  // ****************************************
  // settings fields
  // ****************************************
  always_comb begin
    SETTINGS = '0;
    SETTINGS.backlight_on                    = sy.bank[0][0];      // [RULE_07]
    SETTINGS.bias_supplies_on                = sy.bank[0][1];      // [RULE_07]
    SETTINGS.brightness_code = {sy.bank[2], sy.bank[1][2:0]};      // [RULE_08]
    SETTINGS.frequency_switch_threshold      = sy.bank[5];         // [RULE_11]
    SETTINGS.linear_curve_select             = sy.bank[6][5];      // [RULE_12]
    SETTINGS.single_string_mode              = sy.bank[6][3];      // [RULE_12]
    SETTINGS.small_inductor_select           = sy.bank[6][2];      // [RULE_12]
    SETTINGS.switch_current_limit            = sy.bank[6][1:0];    // [RULE_12]
    SETTINGS.comp_integral_select            = sy.bank[7][7:6];    // [RULE_13]
    SETTINGS.comp_proportional_select        = sy.bank[7][5:4];    // [RULE_13]
    SETTINGS.automatic_frequency_mode        = sy.bank[7][3];      // [RULE_13]
    SETTINGS.boost_overvoltage_target        = sy.bank[7][2:1];    // [RULE_13]
    SETTINGS.boost_frequency_select          = sy.boost_hi;        // [RULE_11]
    SETTINGS.pwm_measure_edge_select         = sy.bank[8][7];      // [RULE_14]
    SETTINGS.pwm_active_high                 = sy.bank[8][6];      // [RULE_14]
    SETTINGS.pwm_hysteresis_select           = sy.bank[8][5:4];    // [RULE_15]
    SETTINGS.brightness_source_select        = sy.bank[8][3:2];    // [RULE_16]
    SETTINGS.advanced_ramp_enable            = sy.bank[8][1];      // [RULE_17]
    SETTINGS.dither_disable                  = sy.bank[8][0];      // [RULE_17]
    SETTINGS.ramp_time_select                = sy.bank[9][7:4];    // [RULE_18]
    SETTINGS.dither_rate_select              = sy.bank[9][3:0];    // [RULE_19]
    SETTINGS.discharge_enable                = sy.bank[10][6:3];   // [RULE_20]
    SETTINGS.positive_bias_regulator         = sy.bank[10][2];     // [RULE_20]
    SETTINGS.negative_bias_pump              = sy.bank[10][1];     // [RULE_20]
    SETTINGS.reference_regulator             = sy.bank[10][0];     // [RULE_20]
    SETTINGS.controller_supply_startup_wait  = sy.bank[11][6:4];   // [RULE_21]
    SETTINGS.controller_supply_shutdown_wait = sy.bank[11][3:1];   // [RULE_21]
    SETTINGS.controller_supply_regulator     = sy.bank[11][0];     // [RULE_21]
    SETTINGS.controller_supply_level         = sy.bank[12][7:6];   // [RULE_22]
    SETTINGS.bias_boost_level                = sy.bank[12][5:0];   // [RULE_22]
  end

  // ****************************************
  // assertions and covers
  // ****************************************
  chk_addr_reject: assert property (@(posedge SCL_CLK) disable iff (RST) // [RULE_23]
    (lk.phase == bbr_pkg::BBR_ADDR && lk.cnt == bbr_pkg::ACK_SLOT && !lk.ack_ok
     && !start_pend && !stop_pend) |=> (lk.phase == bbr_pkg::BBR_IDLE))
    else $error("unmatched slave address not dropped");

  chk_addr_match: assert property (@(posedge SCL_CLK) disable iff (RST) // [RULE_23]
    (lk.phase == bbr_pkg::BBR_ADDR && lk.cnt == bbr_pkg::ACK_SLOT && lk.ack_ok)
    |-> (lk.shift[7:1] == bbr_pkg::SLAVE_ADDR))
    else $error("acked a foreign slave address");

  chk_ack_drive: assert property (@(posedge SCL_CLK) disable iff (RST) // [RULE_01]
    (lk.phase != bbr_pkg::BBR_IDLE && lk.phase != bbr_pkg::BBR_RD &&
     lk.cnt == bbr_pkg::ACK_SLOT) |-> (SDA_OE == lk.ack_ok))
    else $error("ack slot drive wrong");

  chk_read_bits: assert property (@(posedge SCL_CLK) disable iff (RST) // [RULE_05]
    (lk.phase == bbr_pkg::BBR_RD && lk.cnt != bbr_pkg::ACK_SLOT)
    |-> (SDA_OE == !lk.shift[7]))
    else $error("read bit not on data line");

  chk_write_incr: assert property (@(posedge SCL_CLK) disable iff (RST) // [RULE_02]
    (lk.phase == bbr_pkg::BBR_WR && lk.cnt == bbr_pkg::ACK_SLOT &&
     !start_pend && !stop_pend) |=> (lk.ptr == $past(lk.ptr) + 8'h01) ##0
     (lk.wr_tgl != $past(lk.wr_tgl)))
    else $error("write pointer not advanced");

  chk_read_incr: assert property (@(posedge SCL_CLK) disable iff (RST) // [RULE_05]
    (lk.phase == bbr_pkg::BBR_RD && lk.cnt == bbr_pkg::ACK_SLOT && !SDA_IN &&
     !start_pend && !stop_pend) |=> (lk.ptr == $past(lk.ptr) + 8'h01) ##1
     (lk.phase == bbr_pkg::BBR_RD))
    else $error("read pointer not advanced");

  chk_ctrl_write: assert property (@(posedge SCL_CLK) disable iff (RST) // [RULE_25]
    (lk.phase == bbr_pkg::BBR_WR && lk.cnt == bbr_pkg::ACK_SLOT &&
     lk.ptr == bbr_pkg::OFF_DEVICE_CONTROL && !start_pend && !stop_pend)
    |=> (lk.bank[0] == ($past(lk.shift) & 8'h03)))
    else $error("control write not masked");

  // register address byte loads the pointer
  chk_reg_ptr: assert property (@(posedge SCL_CLK) disable iff (RST) // [RULE_01]
    (lk.phase == bbr_pkg::BBR_REGA && lk.cnt == bbr_pkg::ACK_SLOT &&
     !start_pend && !stop_pend) |=> (lk.ptr == $past(lk.shift)))
    else $error("register address not loaded");

  // master nack on a read byte ends the transfer
  chk_read_nack: assert property (@(posedge SCL_CLK) disable iff (RST) // [RULE_06]
    (lk.phase == bbr_pkg::BBR_RD && lk.cnt == bbr_pkg::ACK_SLOT && SDA_IN &&
     !start_pend && !stop_pend) |=> (lk.phase == bbr_pkg::BBR_IDLE))
    else $error("read not ended by nack");

  chk_flag_set: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE_10]
    (sy.fault_sync[0] ##1 !clr_evt) |-> sy.flags[0] [*2])
    else $error("fault event lost");

  chk_flag_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE_24]
    (sy.flags[3] && !clr_evt) |=> sy.flags[3])
    else $error("undervoltage flag dropped without clear");

  // write of one clears the undervoltage flag when no new event
  chk_flag_clear: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE_24]
    (clr_evt && lk.clr_mask[3] && !sy.fault_sync[3]) |=> !sy.flags[3])
    else $error("undervoltage flag not cleared");

  chk_auto_freq: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE_11]
    (sy.bank[7][3] && !wr_evt) |=> (SETTINGS.boost_frequency_select ==
     ($past(sy.bank[2]) > $past(sy.bank[5]))))
    else $error("auto frequency select wrong");

  cov_burst_write: cover property (@(posedge SCL_CLK) disable iff (RST)
    (lk.phase == bbr_pkg::BBR_WR && lk.cnt == bbr_pkg::ACK_SLOT) ##9
    (lk.phase == bbr_pkg::BBR_WR && lk.cnt == bbr_pkg::ACK_SLOT));

  cov_burst_read: cover property (@(posedge SCL_CLK) disable iff (RST)
    (lk.phase == bbr_pkg::BBR_RD && lk.cnt == bbr_pkg::ACK_SLOT && !SDA_IN));

  cov_foreign_addr: cover property (@(posedge SCL_CLK) disable iff (RST)
    (lk.phase == bbr_pkg::BBR_ADDR && lk.cnt == bbr_pkg::ACK_SLOT && !lk.ack_ok));

  cov_flag_clear: cover property (@(posedge SYS_CLK) disable iff (RST)
    (clr_evt && sy.flags[3] && !sy.fault_sync[3]));

endmodule

/* tb/bbr_host_master.sv */
// two-wire bus master model facing the register port
// assumes the bench resolves the data wire with a pull-up
module bbr_host_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // start or repeated start, data falls while clock high
  task automatic start();
    if (!scl) begin
      #12 sda_low = 1'b0;
      #12 scl = 1'b1;
    end
    #12 sda_low = 1'b1;
    #12 scl = 1'b0;
  endtask
  // stop, data rises while clock high
  task automatic stop();
    #12 sda_low = 1'b1;
    #12 scl = 1'b1;
    #12 sda_low = 1'b0;
    #12;
  endtask
  // byte out msb first, then sample the slave ack
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #12 sda_low = ~b[i];
      #12 scl = 1'b1;
      #24 scl = 1'b0;
    end
    #12 sda_low = 1'b0;
    #12 scl = 1'b1;
    #12 ack = ~sda;
    #12 scl = 1'b0;
  endtask
  // byte in, then ack to go on or nack on the last
  task automatic get(input logic more, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #12 sda_low = 1'b0;
      #12 scl = 1'b1;
      #12 b[i] = sda;
      #12 scl = 1'b0;
    end
    #12 sda_low = more;
    #12 scl = 1'b1;
    #24 scl = 1'b0;
  endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench of the serial register port
// assumes the host master model owns the bus clock
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      SYS_CLK = 1'b0;
  logic                      RST = 1'b1;
  logic                      sda_oe;
  logic                      sda_out;
  logic                      sda;
  logic                      scl;
  logic                      sda_low;
  logic                      ack;
  logic                      pg = 1'b1;
  bbr_pkg::bbr_fault_type    faults = '0;
  bbr_pkg::bbr_settings_type set;
  int                        mismatches = 0;
  int                        checks = 0;
  int                        cycles = 0;
  always #12.5 SYS_CLK = ~SYS_CLK;
  // open-drain data wire with pull-up, pad shows its output value while enabled
  assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  bbr_register_port dut (.SYS_CLK(SYS_CLK), .RST(RST), .SCL_CLK(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .FAULT_EVENTS(faults), .POWER_GOOD(pg),
    .SETTINGS(set));
  bbr_host_master host (.scl(scl), .sda_low(sda_low), .sda(sda));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d [$]);
    host.start();
    host.put(8'h52, ack);
    check("addr ack", ack, 1'b1);
    host.put(r, ack);
    check("reg ack", ack, 1'b1);
    foreach (d[i]) begin
      host.put(d[i], ack);
      check("data ack", ack, 1'b1);
    end
    host.stop();
    repeat (8) @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] r, input logic [7:0] e [$]);
    logic [7:0] b;
    host.start();
    host.put(8'h52, ack);
    host.put(r, ack);
    host.start();
    host.put(8'h53, ack);
    check("rd ack", ack, 1'b1);
    foreach (e[i]) begin
      host.get(i < e.size() - 1, b);
      check("rd data", b, e[i]);
    end
    host.stop();
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (6) @(posedge SYS_CLK);
    #1 RST = 1'b0;
    repeat (2) @(posedge SYS_CLK);
    #1;
    check("bl on", set.backlight_on, 1'b1);
    rd(8'h00, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'hcf});
    $display("test reset done");
    wr(8'h00, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf6, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff});
    rd(8'h00, '{8'h03, 8'h07, 8'hff, 8'h00, 8'h01, 8'hff, 8'h2f, 8'hf6, 8'hff, 8'hff,
      8'h7f, 8'h7f, 8'hff, 8'h00});
    check("lcd on", set.bias_supplies_on, 1'b1);
    check("ilim", set.switch_current_limit, 2'b11);
    check("dither", set.dither_disable, 1'b1);
    check("ramp", set.ramp_time_select, 4'hf);
    check("boost lvl", set.bias_boost_level, 6'h3f);
    $display("test burst done");
    wr(8'h01, '{8'h05, 8'ha3, 8'h00, 8'h00, 8'ha3, 8'h00, 8'h08});
    check("brt", set.brightness_code, {8'ha3, 3'h5});
    check("thres", set.frequency_switch_threshold, 8'ha3);
    check("auto mode", set.automatic_frequency_mode, 1'b1);
    check("freq eq", set.boost_frequency_select, 1'b0);
    wr(8'h02, '{8'ha4});
    check("freq gt", set.boost_frequency_select, 1'b1);
    rd(8'h07, '{8'h09});
    $display("test auto done");
    wr(8'h08, '{8'h96, 8'h5a, 8'h35, 8'h2b, 8'h9e});
    check("pwm edge", set.pwm_measure_edge_select, 1'b1);
    check("pwm level", set.pwm_active_high, 1'b0);
    check("hyst", set.pwm_hysteresis_select, 2'b01);
    check("source", set.brightness_source_select, 2'b01);
    check("adv ramp", set.advanced_ramp_enable, 1'b1);
    check("ramp time", set.ramp_time_select, 4'h5);
    check("dither rate", set.dither_rate_select, 4'ha);
    check("discharge", set.discharge_enable, 4'h6);
    check("bias regs", {set.positive_bias_regulator, set.negative_bias_pump,
      set.reference_regulator}, 3'b101);
    check("startup", set.controller_supply_startup_wait, 3'h2);
    check("shutdown", set.controller_supply_shutdown_wait, 3'h5);
    check("ctrl reg", set.controller_supply_regulator, 1'b1);
    check("ctrl lvl", set.controller_supply_level, 2'b10);
    check("bias lvl", set.bias_boost_level, 6'h1e);
    $display("test config done");
    host.start();
    host.put(8'h50, ack);
    check("foreign", ack, 1'b0);
    host.stop();
    @(posedge SYS_CLK);
    #1 faults = '1;
    repeat (3) @(posedge SYS_CLK);
    #1 faults = '0;
    repeat (4) @(posedge SYS_CLK);
    rd(8'h03, '{8'hff, 8'h0f});
    wr(8'h03, '{8'h01});
    #1 pg = 1'b0;
    repeat (4) @(posedge SYS_CLK);
    rd(8'h03, '{8'hfe, 8'h0e});
    $display("test flags done");
    close_out();
  end
endmodule
